// ---- src/cpu_bus_cycle_sequencer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_defs.vh"

module cpu_bus_cycle_sequencer (
   // clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // step request
   input  wire        step_valid,
   input  wire [2:0]  step_kind,
   input  wire [3:0]  step_mode,
   input  wire [15:0] step_offset,
   input  wire [7:0]  step_wdata,
   input  wire [7:0]  vector_low,
   // register loads
   input  wire        pc_load,
   input  wire [15:0] pc_value,
   input  wire        index_load,
   input  wire [15:0] index_value,
   input  wire        sp_load,
   input  wire [15:0] sp_value,
   // interrupt pin
   input  wire        irq_pin,
   // opcode decode
   input  wire [7:0]  opcode,
   input  wire        opcode_prefixed,
   output reg  [3:0]  decoded_mode_q,
   output reg  [1:0]  decoded_length_q,
   // system bus
   output reg  [15:0] bus_addr_q,
   output reg         bus_rd_q,
   output reg         bus_wr_q,
   output reg  [7:0]  bus_wdata_q,
   input  wire [7:0]  bus_rdata,
   // status
   output reg         step_ready_q,
   output reg         step_done_q,
   output reg  [7:0]  step_rdata_q,
   output reg  [15:0] vector_q,
   output reg  [15:0] pc_q,
   output reg  [15:0] index_q,
   output reg  [15:0] sp_q,
   output reg         imask_q,
   output reg         halted_q
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_VEC_HI = 2'h1;
   localparam [1:0] ST_VEC_LO = 2'h2;
   localparam [1:0] ST_HALT   = 2'h3;

   reg  [1:0]  state_q;
   reg  [1:0]  data_sel_q;
   reg         irq_meta_q;
   reg         irq_sync_q;
   reg  [15:0] ea_d;
   reg         post_inc_d;
   wire [3:0]  dec_mode;
   wire [1:0]  dec_length;

   // ----------------------------------------------------------------
   // opcode decode
   // ----------------------------------------------------------------
   opcode_mode_decoder u_decoder (
      .opcode   (opcode),
      .prefixed (opcode_prefixed),
      .mode     (dec_mode),
      .length   (dec_length)
   );

   // ----------------------------------------------------------------
   // effective address
   // ----------------------------------------------------------------
   always @* begin
      post_inc_d = 1'b0;
      case (step_mode)
         `MODE_DIR:  ea_d = {`DIRECT_PAGE, step_offset[7:0]};
         `MODE_EXT:  ea_d = step_offset;
         `MODE_IX:   ea_d = index_q;
         `MODE_IX1:  ea_d = index_q + {8'h00, step_offset[7:0]};
         `INDEX_LONG_OFFSET_MODE: ea_d = index_q + step_offset;
         `INDEX_POSTINC_MODE: begin
            ea_d       = index_q;
            post_inc_d = 1'b1;
         end
         `INDEX_SHORT_OFFSET_POSTINC_MODE: begin
            ea_d       = index_q + {8'h00, step_offset[7:0]};
            post_inc_d = 1'b1;
         end
         `STACK_SHORT_OFFSET_MODE: ea_d = sp_q + {8'h00, step_offset[7:0]};
         `STACK_LONG_OFFSET_MODE:  ea_d = sp_q + step_offset;
         default:    ea_d = pc_q;
      endcase
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!resetn) begin
         state_q          <= ST_IDLE;
         data_sel_q       <= 2'h0;
         irq_meta_q       <= 1'b0;
         irq_sync_q       <= 1'b0;
         decoded_mode_q   <= `MODE_INH;
         decoded_length_q <= 2'd1;
         bus_addr_q       <= 16'h0000;
         bus_rd_q         <= 1'b0;
         bus_wr_q         <= 1'b0;
         bus_wdata_q      <= 8'h00;
         step_ready_q     <= 1'b0;
         step_done_q      <= 1'b0;
         step_rdata_q     <= 8'h00;
         vector_q         <= 16'h0000;
         pc_q             <= `PC_RESET;
         index_q          <= `IX_RESET;
         sp_q             <= `SP_RESET;
         imask_q          <= `IMASK_RESET;
         halted_q         <= 1'b0;
      end else begin
         irq_meta_q       <= irq_pin;
         irq_sync_q       <= irq_meta_q;
         decoded_mode_q   <= dec_mode;
         decoded_length_q <= dec_length;
         bus_rd_q         <= 1'b0;
         bus_wr_q         <= 1'b0;
         step_done_q      <= 1'b0;
         data_sel_q       <= 2'h0;
         // read data of the previous bus cycle
         if (data_sel_q == 2'h1) begin
            step_rdata_q <= bus_rdata;
            step_done_q  <= 1'b1;
         end else if (data_sel_q == 2'h2) begin
            vector_q[15:8] <= bus_rdata;
         end else if (data_sel_q == 2'h3) begin
            vector_q[7:0] <= bus_rdata;
            step_done_q   <= 1'b1;
         end
         if (pc_load) begin
            pc_q <= pc_value;
         end
         if (index_load) begin
            index_q <= index_value;
         end
         if (sp_load) begin
            sp_q <= sp_value;
         end
         case (state_q)
            ST_IDLE: begin
               step_ready_q <= 1'b1;
               if (step_valid && step_ready_q) begin
                  case (step_kind)
                     `STEP_FREE: begin
                        bus_addr_q  <= pc_q;
                        bus_rd_q    <= 1'b1;
                        step_done_q <= 1'b1;
                     end
                     `STEP_FETCH: begin
                        bus_addr_q <= pc_q;
                        bus_rd_q   <= 1'b1;
                        data_sel_q <= 2'h1;
                        pc_q       <= pc_q + 16'h0001;
                     end
                     `STEP_READ: begin
                        bus_addr_q <= ea_d;
                        bus_rd_q   <= 1'b1;
                        data_sel_q <= 2'h1;
                        if (post_inc_d) begin
                           index_q <= index_q + 16'h0001;
                        end
                     end
                     `STEP_WRITE: begin
                        bus_addr_q  <= ea_d;
                        bus_wr_q    <= 1'b1;
                        bus_wdata_q <= step_wdata;
                        step_done_q <= 1'b1;
                        if (post_inc_d) begin
                           index_q <= index_q + 16'h0001;
                        end
                     end
                     `STEP_PUSH: begin
                        bus_addr_q  <= sp_q;
                        bus_wr_q    <= 1'b1;
                        bus_wdata_q <= step_wdata;
                        sp_q        <= sp_q - 16'h0001;
                        step_done_q <= 1'b1;
                     end
                     `STEP_POP: begin
                        bus_addr_q <= sp_q + 16'h0001;
                        bus_rd_q   <= 1'b1;
                        sp_q       <= sp_q + 16'h0001;
                        data_sel_q <= 2'h1;
                     end
                     `STEP_VECTOR: begin
                        bus_addr_q   <= {`VECTOR_PAGE, vector_low};
                        bus_rd_q     <= 1'b1;
                        data_sel_q   <= 2'h2;
                        step_ready_q <= 1'b0;
                        state_q      <= ST_VEC_HI;
                     end
                     default: begin
                        imask_q      <= 1'b0;
                        halted_q     <= 1'b1;
                        step_ready_q <= 1'b0;
                        state_q      <= ST_HALT;
                     end
                  endcase
               end
            end
            ST_VEC_HI: begin
               bus_addr_q <= {`VECTOR_PAGE, vector_low + 8'h01};
               bus_rd_q   <= 1'b1;
               data_sel_q <= 2'h3;
               state_q    <= ST_VEC_LO;
            end
            ST_VEC_LO: begin
               step_ready_q <= 1'b1;
               state_q      <= ST_IDLE;
            end
            ST_HALT: begin
               if (irq_sync_q) begin
                  halted_q     <= 1'b0;
                  step_done_q  <= 1'b1;
                  step_ready_q <= 1'b1;
                  state_q      <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ---- src/bus_seq_defs.vh ----
`ifndef BUS_SEQ_DEFS_VH
`define BUS_SEQ_DEFS_VH

// ----------------------------------------------------------------
// step kinds
// ----------------------------------------------------------------
`define STEP_FREE      3'h0
`define STEP_FETCH     3'h1
`define STEP_READ      3'h2
`define STEP_WRITE     3'h3
`define STEP_PUSH      3'h4
`define STEP_POP       3'h5
`define STEP_VECTOR    3'h6
`define STEP_WAIT      3'h7

// ----------------------------------------------------------------
// addressing modes
// ----------------------------------------------------------------
`define MODE_INH       4'h0
`define MODE_IMM       4'h1
`define MODE_DIR       4'h2
`define MODE_EXT       4'h3
`define MODE_IX        4'h4
`define MODE_IX1       4'h5
`define INDEX_LONG_OFFSET_MODE          4'h6
`define INDEX_POSTINC_MODE              4'h7
`define INDEX_SHORT_OFFSET_POSTINC_MODE 4'h8
`define STACK_SHORT_OFFSET_MODE         4'h9
`define STACK_LONG_OFFSET_MODE          4'ha
`define MODE_REL       4'hb

// ----------------------------------------------------------------
// constants and reset values
// ----------------------------------------------------------------
`define VECTOR_PAGE    8'hff
`define DIRECT_PAGE    8'h00
`define SP_PREFIX      8'h9e
`define PC_RESET       16'h0000
`define SP_RESET       16'h00ff
`define IX_RESET       16'h0000
`define IMASK_RESET    1'b1

`endif

// ---- src/opcode_mode_decoder.v ----
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_defs.vh"

module opcode_mode_decoder (
   // opcode in
   input  wire [7:0] opcode,
   input  wire       prefixed,
   // decode out
   output reg  [3:0] mode,
   output reg  [1:0] length
);

   always @* begin
      mode   = `MODE_INH;
      length = 2'd1;
      case (opcode[7:4])
         4'h0, 4'h1: begin
            mode   = `MODE_DIR;
            length = (opcode[7:4] == 4'h0) ? 2'd3 : 2'd2;
         end
         4'h2: begin
            mode   = `MODE_REL;
            length = 2'd2;
         end
         4'h3: begin
            mode   = `MODE_DIR;
            length = 2'd2;
         end
         4'h6: begin
            if (prefixed) begin
               mode = `STACK_SHORT_OFFSET_MODE;
            end else if (opcode == 8'h61) begin
               mode = `INDEX_SHORT_OFFSET_POSTINC_MODE;
            end else begin
               mode = `MODE_IX1;
            end
            length = (opcode == 8'h61) ? 2'd3 : 2'd2;
         end
         4'h7: begin
            mode   = (opcode == 8'h71) ? `INDEX_POSTINC_MODE : `MODE_IX;
            length = (opcode == 8'h71) ? 2'd2 : 2'd1;
         end
         4'h9: begin
            mode   = (opcode[3:0] < 4'h4) ? `MODE_REL : `MODE_INH;
            length = (opcode[3:0] < 4'h4) ? 2'd2 : 2'd1;
         end
         4'ha: begin
            mode   = `MODE_IMM;
            length = 2'd2;
         end
         4'hb: begin
            mode   = `MODE_DIR;
            length = 2'd2;
         end
         4'hc: begin
            mode   = `MODE_EXT;
            length = 2'd3;
         end
         4'hd: begin
            mode   = prefixed ? `STACK_LONG_OFFSET_MODE : `INDEX_LONG_OFFSET_MODE;
            length = 2'd3;
         end
         4'he: begin
            mode   = prefixed ? `STACK_SHORT_OFFSET_MODE : `MODE_IX1;
            length = 2'd2;
         end
         4'hf: begin
            mode   = `MODE_IX;
            length = 2'd1;
         end
         default: begin
            mode   = `MODE_INH;
            length = 2'd1;
         end
      endcase
   end

endmodule
`default_nettype wire

// ---- testbench/bus_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module bus_mem_model (
   // clock
   input wire logic        sys_clk,
   // system bus
   input wire logic [15:0] bus_addr_q,
   input wire logic        bus_rd_q,
   input wire logic        bus_wr_q,
   input wire logic [7:0]  bus_wdata_q,
   output logic [7:0]      bus_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] last_q = 8'h00;

   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;

   // released bus shows the inverse of the last byte
   assign bus_rdata = bus_rd_q ? mem[bus_addr_q[7:0]] : ~last_q;

   always @(posedge sys_clk) begin
      if (bus_wr_q) mem[bus_addr_q[7:0]] <= bus_wdata_q;
      if (bus_rd_q) last_q <= bus_rdata;
   end
endmodule
`default_nettype wire

// ---- testbench/bus_seq_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_defs.vh"

module bus_seq_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // step request
   input wire logic        step_valid,
   input wire logic [2:0]  step_kind,
   input wire logic [3:0]  step_mode,
   input wire logic [15:0] step_offset,
   input wire logic [7:0]  step_wdata,
   input wire logic [7:0]  vector_low,
   // system bus
   input wire logic [15:0] bus_addr_q,
   input wire logic        bus_rd_q,
   input wire logic        bus_wr_q,
   input wire logic [7:0]  bus_wdata_q,
   input wire logic [7:0]  bus_rdata,
   // status
   input wire logic        step_ready_q,
   input wire logic        step_done_q,
   input wire logic [15:0] vector_q,
   input wire logic [15:0] pc_q,
   input wire logic [15:0] index_q,
   input wire logic [15:0] sp_q,
   input wire logic        imask_q,
   input wire logic        halted_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   wire tk = step_valid && step_ready_q;
   wire rw = step_kind == `STEP_READ || step_kind == `STEP_WRITE;

   property p_free;
      tk && step_kind == `STEP_FREE |=> bus_rd_q && !bus_wr_q && step_done_q;
   endproperty
   a_free: assert property (p_free) else $error("free step not a read");
   property p_fetch;
      tk && step_kind == `STEP_FETCH |=> bus_rd_q && bus_addr_q == $past(pc_q)
         && pc_q == $past(pc_q) + 16'h0001;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch address wrong");
   property p_write;
      tk && step_kind == `STEP_WRITE |=> bus_wr_q && !bus_rd_q && step_done_q
         && bus_wdata_q == $past(step_wdata);
   endproperty
   a_write: assert property (p_write) else $error("write cycle wrong");
   property p_push;
      tk && step_kind == `STEP_PUSH |=> bus_wr_q && bus_addr_q == $past(sp_q)
         && sp_q == $past(sp_q) - 16'h0001;
   endproperty
   a_push: assert property (p_push) else $error("push wrong");
   property p_pop;
      tk && step_kind == `STEP_POP |=> bus_rd_q && bus_addr_q == $past(sp_q) + 16'h0001;
   endproperty
   a_pop: assert property (p_pop) else $error("pop wrong");
   property p_vec;
      tk && step_kind == `STEP_VECTOR |=> bus_rd_q && bus_addr_q == {8'hff, $past(vector_low)}
         ##1 bus_rd_q && bus_addr_q == {8'hff, $past(vector_low) + 8'h01}
         ##1 step_done_q && vector_q == {$past(bus_rdata, 2), $past(bus_rdata)};
   endproperty
   a_vec: assert property (p_vec) else $error("vector order wrong");
   property p_ixp;
      tk && rw && step_mode == `INDEX_POSTINC_MODE |=> bus_addr_q == $past(index_q)
         && index_q == $past(index_q) + 16'h0001;
   endproperty
   a_ixp: assert property (p_ixp) else $error("post-increment wrong");
   property p_stack_long;
      tk && rw && step_mode == `STACK_LONG_OFFSET_MODE
         |=> bus_addr_q == $past(sp_q) + $past(step_offset);
   endproperty
   a_stack_long: assert property (p_stack_long) else $error("stack offset wrong");
   property p_wait;
      tk && step_kind == `STEP_WAIT |=> halted_q && !imask_q;
   endproperty
   a_wait: assert property (p_wait) else $error("wait did not halt");

   c_vec: cover property (tk && step_kind == `STEP_VECTOR);
   c_pop: cover property (tk && step_kind == `STEP_POP);
   c_wake: cover property (halted_q ##1 !halted_q);
endmodule

bind cpu_bus_cycle_sequencer bus_seq_chk chk (
   .sys_clk(sys_clk), .resetn(resetn), .step_valid(step_valid), .step_kind(step_kind),
   .step_mode(step_mode), .step_offset(step_offset), .step_wdata(step_wdata),
   .vector_low(vector_low), .bus_addr_q(bus_addr_q), .bus_rd_q(bus_rd_q),
   .bus_wr_q(bus_wr_q), .bus_wdata_q(bus_wdata_q), .bus_rdata(bus_rdata),
   .step_ready_q(step_ready_q), .step_done_q(step_done_q), .vector_q(vector_q),
   .pc_q(pc_q), .index_q(index_q), .sp_q(sp_q), .imask_q(imask_q), .halted_q(halted_q)
);
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_defs.vh"

module testbench;
   logic        sys_clk, resetn = 0, step_valid = 0, pc_load = 0, index_load = 0, sp_load = 0;
   logic        irq_pin = 0, opcode_prefixed = 0, bus_rd_q, bus_wr_q, step_ready_q;
   logic        step_done_q, imask_q, halted_q, sr, sw, dn;
   logic [2:0]  step_kind = 3'h0;
   logic [3:0]  step_mode = 4'h0, decoded_mode_q;
   logic [1:0]  decoded_length_q;
   logic [7:0]  step_wdata = 8'h00, vector_low = 8'h10, opcode = 8'h00;
   logic [7:0]  bus_wdata_q, bus_rdata, step_rdata_q, sd;
   logic [15:0] step_offset = 0, pc_value = 0, index_value = 0, sp_value = 0;
   logic [15:0] bus_addr_q, vector_q, pc_q, index_q, sp_q, sa;
   int          fail_count = 0, cmp_count = 0;

   cpu_bus_cycle_sequencer dut (
      .sys_clk(sys_clk), .resetn(resetn), .step_valid(step_valid), .step_kind(step_kind),
      .step_mode(step_mode), .step_offset(step_offset), .step_wdata(step_wdata),
      .vector_low(vector_low), .pc_load(pc_load), .pc_value(pc_value),
      .index_load(index_load), .index_value(index_value), .sp_load(sp_load),
      .sp_value(sp_value), .irq_pin(irq_pin), .opcode(opcode),
      .opcode_prefixed(opcode_prefixed), .decoded_mode_q(decoded_mode_q),
      .decoded_length_q(decoded_length_q), .bus_addr_q(bus_addr_q), .bus_rd_q(bus_rd_q),
      .bus_wr_q(bus_wr_q), .bus_wdata_q(bus_wdata_q), .bus_rdata(bus_rdata),
      .step_ready_q(step_ready_q), .step_done_q(step_done_q), .step_rdata_q(step_rdata_q),
      .vector_q(vector_q), .pc_q(pc_q), .index_q(index_q), .sp_q(sp_q), .imask_q(imask_q),
      .halted_q(halted_q));
   bus_mem_model mem (.sys_clk(sys_clk), .bus_addr_q(bus_addr_q), .bus_rd_q(bus_rd_q),
      .bus_wr_q(bus_wr_q), .bus_wdata_q(bus_wdata_q), .bus_rdata(bus_rdata));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // one step: issue when ready, note first bus cycle, await done
   // ---------------------------------------------------------------
   task automatic step(input logic [2:0] k, input logic [3:0] m, input logic [15:0] o,
                       input logic [7:0] wd);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (step_ready_q !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      step_kind = k;
      step_mode = m;
      step_offset = o;
      step_wdata = wd;
      step_valid = 1'b1;
      @(negedge sys_clk);
      step_valid = 1'b0;
      sa = bus_addr_q;
      sr = bus_rd_q;
      sw = bus_wr_q;
      dn = step_done_q;
      for (n = 0; n < 6 && dn !== 1'b1; n++) begin
         @(negedge sys_clk);
         dn = step_done_q;
      end
      sd = step_rdata_q;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   task automatic t_fetch;
      @(negedge sys_clk);
      {pc_load, index_load, sp_load} = 3'b111;
      {pc_value, index_value, sp_value} = {16'h1234, 16'h3000, 16'h0400};
      @(negedge sys_clk);
      {pc_load, index_load, sp_load} = 3'b000;
      step(`STEP_FETCH, `MODE_INH, 0, 0);
      chk(sa, 16'h1234);
      chk(sd, 8'h34 ^ 8'h5a);
      step(`STEP_FETCH, `MODE_INH, 0, 0);
      chk(sa, 16'h1235);
      step(`STEP_FREE, `MODE_INH, 0, 0);
      chk({sr, sw, dn}, 3'b101);
      chk(pc_q, 16'h1236);
      $display("fetch and free test done");
   endtask

   task automatic t_bus;
      step(`STEP_WRITE, `MODE_EXT, 16'h2040, 8'ha5);
      chk({sa, sw}, {16'h2040, 1'b1});
      step(`STEP_READ, `MODE_EXT, 16'h2040, 0);
      chk({sr, sd}, {1'b1, 8'ha5});
      step(`STEP_PUSH, `MODE_INH, 0, 8'h3c);
      step(`STEP_PUSH, `MODE_INH, 0, 8'hc3);
      chk({sa, sp_q}, {16'h03ff, 16'h03fe});
      step(`STEP_POP, `MODE_INH, 0, 0);
      chk({sa, sd}, {16'h03ff, 8'hc3});
      step(`STEP_POP, `MODE_INH, 0, 0);
      chk({sd, sp_q}, {8'h3c, 16'h0400});
      $display("operand and stack test done");
   endtask

   task automatic t_modes;
      step(`STEP_READ, `INDEX_POSTINC_MODE, 0, 0);
      chk({sa, index_q}, {16'h3000, 16'h3001});
      step(`STEP_READ, `INDEX_SHORT_OFFSET_POSTINC_MODE, 16'h0010, 0);
      chk({sa, index_q}, {16'h3011, 16'h3002});
      step(`STEP_READ, `INDEX_LONG_OFFSET_MODE, 16'h1234, 0);
      chk(sa, 16'h4236);
      step(`STEP_WRITE, `STACK_SHORT_OFFSET_MODE, 16'h0105, 8'h11);
      chk(sa, 16'h0405);
      step(`STEP_READ, `STACK_LONG_OFFSET_MODE, 16'h0105, 0);
      chk(sa, 16'h0505);
      $display("addressing mode test done");
   endtask

   task automatic t_vector_wait;
      step(`STEP_VECTOR, `MODE_INH, 0, 0);
      chk(sa, 16'hff10);
      chk(vector_q, {8'h10 ^ 8'h5a, 8'h11 ^ 8'h5a});
      step(`STEP_WAIT, `MODE_INH, 0, 0);
      chk({halted_q, imask_q, dn}, 3'b100);
      irq_pin = 1'b1;
      for (int n = 0; n < 8 && dn !== 1'b1; n++) begin
         @(negedge sys_clk);
         dn = step_done_q;
      end
      chk(dn, 1'b1);
      irq_pin = 1'b0;
      $display("vector and wait test done");
   endtask

   task automatic t_decode;
      logic [8:0] op [5] = '{9'h071, 9'h061, 9'h0e6, 9'h166, 9'h1d6};
      logic [3:0] md [5] = '{`INDEX_POSTINC_MODE, `INDEX_SHORT_OFFSET_POSTINC_MODE, `MODE_IX1,
                             `STACK_SHORT_OFFSET_MODE, `STACK_LONG_OFFSET_MODE};
      logic [1:0] ln [5] = '{2'd2, 2'd3, 2'd2, 2'd2, 2'd3};
      foreach (op[i]) begin
         @(negedge sys_clk);
         {opcode_prefixed, opcode} = op[i];
         @(negedge sys_clk);
         chk(decoded_mode_q, md[i]);
         chk(decoded_length_q, ln[i]);
      end
      $display("decode test done");
   endtask

   initial begin
      #100000;
      fail_count++;
      stop_test;
   end

   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      chk({pc_q, sp_q, index_q, imask_q, halted_q},
          {`PC_RESET, `SP_RESET, `IX_RESET, `IMASK_RESET, 1'b0});
      t_fetch;
      t_bus;
      t_modes;
      t_vector_wait;
      t_decode;
      stop_test;
   end
endmodule
`default_nettype wire
